// ===== core/fwb_pkg.sv
// package: command codes, address layout and timing for the buffer-program host sequencer
// ----------------------------------------------------------------------------
// Overview of operation
// - first unlock write: AA at 555 (word) or AAA (byte).
// - second unlock write: 55 at 2AA (word) or 555 (byte).
// - third write: write-to-buffer code 25h at the target sector address.
// - fourth write at sector address: count equals locations minus one.
// - every later pair stays in that line, ascending sequential addresses.
// - confirm 29h at sector address right after last location; device turns busy.
// - host should prefer program-only suspend and resume codes.
// - host writes resume to leave suspend; device continues programming.
// - host leaves at least resume-to-suspend minimum time before next suspend.
// ----------------------------------------------------------------------------
package fwb_pkg;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR_WORD = 26'h0000555;
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR_BYTE = 26'h0000aaa;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR_WORD = 26'h00002aa;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR_BYTE = 26'h0000555;
    localparam logic [DATA_W-1:0] UNLOCK1_DATA      = 16'h00aa;
    localparam logic [DATA_W-1:0] UNLOCK2_DATA      = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_WRITE_BUFFER  = 16'h0025;
    localparam logic [DATA_W-1:0] CMD_CONFIRM       = 16'h0029;
    localparam logic [DATA_W-1:0] CMD_SUSP_COMBINED = 16'h00b0;
    localparam logic [DATA_W-1:0] CMD_SUSP_PROGRAM  = 16'h0051;
    localparam logic [DATA_W-1:0] CMD_RES_COMBINED  = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_RES_PROGRAM   = 16'h0050;
    localparam logic [DATA_W-1:0] CMD_ABORT_RESET   = 16'h00f0;
    localparam logic [CNT_W-1:0]  MAX_COUNT         = 8'hff;
    // line is 512 bytes: 256 words or 512 bytes of byte address
    localparam int LINE_BITS_WORD = 8;
    localparam int LINE_BITS_BYTE = 9;
    localparam int WRITE_PULSE_NS = 50;
    localparam int WRITE_GAP_NS   = 50;
    localparam int RESUME_TO_SUSPEND_MIN_NS = 100000;
    localparam int CLK_PERIOD_NS  = 25;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_GAP_CYC   = (WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESUME_TO_SUSPEND_CYC =
        (RESUME_TO_SUSPEND_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 13;
    // clocks to let the synchronised ready pin catch up after a write
    localparam int READY_SETTLE_CYC = 2;
endpackage : fwb_pkg

// ===== core/fwb_fifo.sv
// synchronous valid/ready fifo for address/data load pairs
`timescale 1ns/10ps
`default_nettype none
module fwb_fifo #(
    parameter int WIDTH = 42,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   level;
    } fwb_fifo_state_t;
    fwb_fifo_state_t state_ff;
    fwb_fifo_state_t nxt_state;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready_out  = (state_ff.level != (AW+1)'(DEPTH));
    assign out_valid_out = (state_ff.level != '0);
    assign out_data_out  = mem_ff[state_ff.rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always_comb begin
        nxt_state = state_ff;
        if (push) begin
            nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
        end
        nxt_state.level = state_ff.level + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem_ff[state_ff.wr_ptr] <= in_data_in;
        end
    end
endmodule : fwb_fifo
`default_nettype wire

// ===== core/fwb_host.sv
// host sequencer: drives buffer program, suspend, resume and abort reset on flash bus
`timescale 1ns/10ps
`default_nettype none
module fwb_host (
    input  wire logic                        ref_clk_in,
    input  wire logic                        rst_b_in,
    // user command side
    input  wire logic                        byte_mode_in,
    input  wire logic                        start_in,
    input  wire logic [fwb_pkg::ADDR_W-1:0]  start_addr_in,
    input  wire logic [fwb_pkg::CNT_W-1:0]   load_count_minus_one_in,
    input  wire logic                        suspend_in,
    input  wire logic                        resume_in,
    input  wire logic                        abort_reset_in,
    input  wire logic                        load_valid_in,
    output logic                             load_ready_out,
    input  wire logic [fwb_pkg::DATA_W-1:0]  program_word_value_in,
    output logic                             busy_out,
    output logic                             done_out,
    output logic                             suspended_out,
    output logic                             refused_out,
    // flash bus
    output logic [fwb_pkg::ADDR_W-1:0]       flash_addr_out,
    output logic [fwb_pkg::DATA_W-1:0]       flash_dq_out,
    output logic                             flash_dq_oe_b_out,
    output logic                             flash_we_b_out,
    output logic                             flash_ce_b_out,
    input  wire logic                        flash_ready_in
);
    localparam int FW = fwb_pkg::ADDR_W + fwb_pkg::DATA_W;
    localparam logic [fwb_pkg::TMR_W-1:0] PULSE_CYC =
        fwb_pkg::TMR_W'(fwb_pkg::WRITE_PULSE_CYC);
    localparam logic [fwb_pkg::TMR_W-1:0] GAP_CYC =
        fwb_pkg::TMR_W'(fwb_pkg::WRITE_GAP_CYC);
    localparam logic [fwb_pkg::TMR_W-1:0] PRS_CYC =
        fwb_pkg::TMR_W'(fwb_pkg::RESUME_TO_SUSPEND_CYC);
    localparam logic [fwb_pkg::TMR_W-1:0] SETTLE_CYC =
        fwb_pkg::TMR_W'(fwb_pkg::READY_SETTLE_CYC);

    typedef enum logic [3:0] {
        ST_IDLE, ST_UNLOCK1, ST_UNLOCK2, ST_WBUF, ST_COUNT, ST_LOAD,
        ST_CONFIRM, ST_BUSY, ST_SUSPEND, ST_SUSPENDED, ST_RESUME, ST_ABRT1,
        ST_ABRT2, ST_ABRT3
    } fwb_phase_t;

    typedef enum logic [1:0] {
        WR_IDLE, WR_PULSE, WR_GAP
    } fwb_wr_t;

    typedef struct packed {
        fwb_phase_t                   phase;
        fwb_wr_t                      wr;
        logic [fwb_pkg::TMR_W-1:0]    tmr;
        logic [fwb_pkg::TMR_W-1:0]    prs_tmr;
        logic [fwb_pkg::ADDR_W-1:0]   sector_select_address;
        logic [fwb_pkg::ADDR_W-1:0]   buffer_line_location;
        logic [fwb_pkg::CNT_W-1:0]    remaining;
        logic                         byte_mode;
        logic [1:0]                   rdy_sync;
        logic [fwb_pkg::ADDR_W-1:0]   addr;
        logic [fwb_pkg::DATA_W-1:0]   dq;
        logic                         dq_oe_b;
        logic                         we_b;
        logic                         ce_b;
        logic                         busy;
        logic                         done;
        logic                         suspended;
        logic                         refused;
        logic                         load_ready;
    } fwb_state_t;

    fwb_state_t              state_ff;
    fwb_state_t              nxt_state;
    logic                    fifo_in_ready;
    logic                    fifo_out_valid;
    logic                    fifo_pop;
    logic [FW-1:0]           fifo_out_data;
    logic [FW-1:0]           fifo_in_data;

    // ------------------------------------------------------------------
    // load pair buffer
    // ------------------------------------------------------------------
    assign fifo_in_data = {state_ff.buffer_line_location, program_word_value_in};

    fwb_fifo #(
        .WIDTH (FW),
        .DEPTH (fwb_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (load_valid_in && state_ff.load_ready),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in_data),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out_data)
    );

    assign fifo_pop = (state_ff.phase == ST_LOAD) && (state_ff.wr == WR_IDLE)
                      && fifo_out_valid;

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb begin
        logic                        issue;
        logic [fwb_pkg::ADDR_W-1:0]  w_addr;
        logic [fwb_pkg::DATA_W-1:0]  w_data;
        logic                        ready_s;
        logic                        wr_done;
        issue  = 1'b0;
        w_addr = '0;
        w_data = '0;
        nxt_state = state_ff;
        nxt_state.rdy_sync = {state_ff.rdy_sync[0], flash_ready_in};
        ready_s = state_ff.rdy_sync[1];
        nxt_state.done    = 1'b0;
        nxt_state.refused = 1'b0;
        if (state_ff.prs_tmr != '0) begin
            nxt_state.prs_tmr = state_ff.prs_tmr - 1'b1;
        end
        wr_done = (state_ff.wr == WR_GAP) && (state_ff.tmr == '0);

        // write-cycle timing engine
        unique case (state_ff.wr)
            WR_IDLE: begin
            end
            WR_PULSE: begin
                if (state_ff.tmr == '0) begin
                    nxt_state.we_b = 1'b1;
                    nxt_state.wr   = WR_GAP;
                    nxt_state.tmr  = GAP_CYC - 1'b1;
                end else begin
                    nxt_state.tmr = state_ff.tmr - 1'b1;
                end
            end
            WR_GAP: begin
                if (state_ff.tmr == '0) begin
                    nxt_state.wr      = WR_IDLE;
                    nxt_state.ce_b    = 1'b1;
                    nxt_state.dq_oe_b = 1'b1;
                end else begin
                    nxt_state.tmr = state_ff.tmr - 1'b1;
                end
            end
        endcase

        unique case (state_ff.phase)
            ST_IDLE: begin
                if (abort_reset_in) begin
                    nxt_state.phase = ST_ABRT1;
                end else if (start_in) begin
                    nxt_state.byte_mode = byte_mode_in;
                    nxt_state.sector_select_address = start_addr_in;
                    nxt_state.buffer_line_location = start_addr_in;
                    nxt_state.remaining = load_count_minus_one_in;
                    nxt_state.load_ready = 1'b1;
                    nxt_state.busy  = 1'b1;
                    nxt_state.phase = ST_UNLOCK1;
                end
            end
            ST_UNLOCK1: begin
                if (state_ff.wr == WR_IDLE) begin
                    issue  = 1'b1;
                    w_addr = state_ff.byte_mode ? fwb_pkg::UNLOCK1_ADDR_BYTE
                                                : fwb_pkg::UNLOCK1_ADDR_WORD;
                    w_data = fwb_pkg::UNLOCK1_DATA;
                    nxt_state.phase = ST_UNLOCK2;
                end
            end
            ST_UNLOCK2: begin
                if (wr_done) begin
                    issue  = 1'b1;
                    w_addr = state_ff.byte_mode ? fwb_pkg::UNLOCK2_ADDR_BYTE
                                                : fwb_pkg::UNLOCK2_ADDR_WORD;
                    w_data = fwb_pkg::UNLOCK2_DATA;
                    nxt_state.phase = ST_WBUF;
                end
            end
            ST_WBUF: begin
                if (wr_done) begin
                    issue  = 1'b1;
                    w_addr = state_ff.sector_select_address;
                    w_data = fwb_pkg::CMD_WRITE_BUFFER;
                    nxt_state.phase = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (wr_done) begin
                    issue  = 1'b1;
                    w_addr = state_ff.sector_select_address;
                    w_data = fwb_pkg::DATA_W'(state_ff.remaining);
                    nxt_state.phase = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (fifo_pop) begin
                    issue  = 1'b1;
                    w_addr = fifo_out_data[FW-1 -: fwb_pkg::ADDR_W];
                    w_data = fifo_out_data[fwb_pkg::DATA_W-1:0];
                    if (state_ff.remaining == '0) begin
                        nxt_state.phase = ST_CONFIRM;
                    end else begin
                        nxt_state.remaining = state_ff.remaining - 1'b1;
                    end
                end
            end
            ST_CONFIRM: begin
                if (wr_done) begin
                    issue  = 1'b1;
                    w_addr = state_ff.sector_select_address;
                    w_data = fwb_pkg::CMD_CONFIRM;
                    nxt_state.phase = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (wr_done) begin
                    // ready pin still shows the state from before the write
                    nxt_state.tmr = SETTLE_CYC;
                end
                if (state_ff.wr == WR_IDLE) begin
                    if (state_ff.tmr != '0) begin
                        nxt_state.tmr = state_ff.tmr - 1'b1;
                    end
                    if (suspend_in && state_ff.prs_tmr == '0) begin
                        nxt_state.phase = ST_SUSPEND;
                    end else if (suspend_in || resume_in) begin
                        nxt_state.refused = 1'b1;
                    end else if (ready_s && state_ff.tmr == '0) begin
                        nxt_state.busy  = 1'b0;
                        nxt_state.done  = 1'b1;
                        nxt_state.phase = ST_IDLE;
                    end
                end
            end
            ST_SUSPEND: begin
                issue  = 1'b1;
                w_addr = state_ff.sector_select_address;
                w_data = fwb_pkg::CMD_SUSP_PROGRAM;
                nxt_state.phase = ST_SUSPENDED;
            end
            ST_SUSPENDED: begin
                if (wr_done) begin
                    nxt_state.suspended = 1'b1;
                end
                if (state_ff.suspended && resume_in) begin
                    issue  = 1'b1;
                    w_addr = state_ff.sector_select_address;
                    w_data = fwb_pkg::CMD_RES_PROGRAM;
                    nxt_state.suspended = 1'b0;
                    nxt_state.prs_tmr = PRS_CYC;
                    nxt_state.phase = ST_RESUME;
                end else if (suspend_in) begin
                    nxt_state.refused = 1'b1;
                end
            end
            ST_RESUME: begin
                if (wr_done) begin
                    nxt_state.tmr   = SETTLE_CYC;
                    nxt_state.phase = ST_BUSY;
                end
            end
            ST_ABRT1: begin
                if (state_ff.wr == WR_IDLE) begin
                    issue  = 1'b1;
                    w_addr = state_ff.byte_mode ? fwb_pkg::UNLOCK1_ADDR_BYTE
                                                : fwb_pkg::UNLOCK1_ADDR_WORD;
                    w_data = fwb_pkg::UNLOCK1_DATA;
                    nxt_state.busy  = 1'b1;
                    nxt_state.phase = ST_ABRT2;
                end
            end
            ST_ABRT2: begin
                if (wr_done) begin
                    issue  = 1'b1;
                    w_addr = state_ff.byte_mode ? fwb_pkg::UNLOCK2_ADDR_BYTE
                                                : fwb_pkg::UNLOCK2_ADDR_WORD;
                    w_data = fwb_pkg::UNLOCK2_DATA;
                    nxt_state.phase = ST_ABRT3;
                end
            end
            ST_ABRT3: begin
                if (wr_done) begin
                    issue  = 1'b1;
                    w_addr = state_ff.byte_mode ? fwb_pkg::UNLOCK1_ADDR_BYTE
                                                : fwb_pkg::UNLOCK1_ADDR_WORD;
                    w_data = fwb_pkg::CMD_ABORT_RESET;
                    nxt_state.busy  = 1'b0;
                    nxt_state.done  = 1'b1;
                    nxt_state.phase = ST_IDLE;
                end
            end
            default: begin
                nxt_state.phase = ST_IDLE;
            end
        endcase

        // user load pairs walk the line in ascending order
        if (load_valid_in && state_ff.load_ready && fifo_in_ready) begin
            nxt_state.buffer_line_location = state_ff.buffer_line_location + 1'b1;
            if (state_ff.buffer_line_location ==
                state_ff.sector_select_address + fwb_pkg::ADDR_W'(load_count_minus_one_in)
                || state_ff.remaining == '0) begin
                nxt_state.load_ready = 1'b0;
            end
        end
        if (state_ff.phase == ST_CONFIRM) begin
            nxt_state.load_ready = 1'b0;
        end

        if (issue) begin
            nxt_state.addr    = w_addr;
            nxt_state.dq      = w_data;
            nxt_state.dq_oe_b = 1'b0;
            nxt_state.ce_b    = 1'b0;
            nxt_state.we_b    = 1'b0;
            nxt_state.wr      = WR_PULSE;
            nxt_state.tmr     = PULSE_CYC - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= '{phase: ST_IDLE, wr: WR_IDLE, dq_oe_b: 1'b1, we_b: 1'b1,
                          ce_b: 1'b1, default: '0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign load_ready_out    = state_ff.load_ready && fifo_in_ready;
    assign busy_out          = state_ff.busy;
    assign done_out          = state_ff.done;
    assign suspended_out     = state_ff.suspended;
    assign refused_out       = state_ff.refused;
    assign flash_addr_out    = state_ff.addr;
    assign flash_dq_out      = state_ff.dq;
    assign flash_dq_oe_b_out = state_ff.dq_oe_b;
    assign flash_we_b_out    = state_ff.we_b;
    assign flash_ce_b_out    = state_ff.ce_b;

    logic wr_done_chk;
    assign wr_done_chk = (state_ff.wr == WR_GAP) && (state_ff.tmr == '0);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_UNLOCK_FIRST: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff.phase == ST_UNLOCK1 && state_ff.wr == WR_IDLE) |=>
        (flash_dq_out == fwb_pkg::UNLOCK1_DATA && !flash_we_b_out))
        else $error("first unlock write wrong");
    AST_UNLOCK_SECOND: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff.phase == ST_UNLOCK2 && wr_done_chk) |=>
        (flash_dq_out == fwb_pkg::UNLOCK2_DATA))
        else $error("second unlock write wrong");
    AST_WBUF_CMD: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff.phase == ST_WBUF && wr_done_chk) |=>
        (flash_dq_out == fwb_pkg::CMD_WRITE_BUFFER
         && flash_addr_out == state_ff.sector_select_address))
        else $error("write-to-buffer command wrong");
    AST_CONFIRM_CMD: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff.phase == ST_CONFIRM && wr_done_chk) |=>
        (flash_dq_out == fwb_pkg::CMD_CONFIRM && state_ff.phase == ST_BUSY))
        else $error("confirm not issued after last load");
    AST_WE_PULSE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $fell(flash_we_b_out) |-> !flash_ce_b_out && !flash_dq_oe_b_out)
        else $error("write strobe without bus drive");
    AST_RESUME_GAP: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff.phase == ST_SUSPEND) |-> (state_ff.prs_tmr == '0))
        else $error("suspend too soon after resume");
    AST_SUSP_CODE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff.phase == ST_SUSPEND) |=> (flash_dq_out == fwb_pkg::CMD_SUSP_PROGRAM))
        else $error("suspend code wrong");
    AST_RESUME_CODE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff.phase == ST_SUSPENDED && state_ff.suspended && resume_in) |=>
        (flash_dq_out == fwb_pkg::CMD_RES_PROGRAM && !suspended_out))
        else $error("resume not written");
endmodule : fwb_host
`default_nettype wire

// ===== tb/fwb_flash_model.sv
// device model: decodes buffer-program writes, busy time and suspend
`timescale 1ns/10ps
`default_nettype none
module fwb_flash_model #(parameter int BUSY_CYC = 400, parameter int SECT_BITS = 16) (
    input  wire logic        ref_clk_in,
    input  wire logic        byte_mode_in,
    input  wire logic [25:0] addr_in,
    input  wire logic [15:0] dq_in,
    input  wire logic        we_b_in,
    input  wire logic        ce_b_in,
    output logic             ready_out
);
    logic [7:0]  code [3] = '{8'haa, 8'h55, 8'h25};
    logic [25:0] sect, nx;
    logic [15:0] sum = '0;
    logic        we_q = 1'b1, susp = 1'b0, aborted = 1'b0, bad, sect_ok, in_line;
    int          st = 0, busy = 0, rem = 0, n = 0, writes = 0, ar = 0, resets = 0;
    assign sect_ok = addr_in >> SECT_BITS == sect >> SECT_BITS;
    assign in_line = n == 0 || addr_in == nx && (byte_mode_in ? nx[8:0] : 9'(nx[7:0])) != 9'h0;
    assign ready_out = busy == 0 || susp;
    always @(posedge ref_clk_in) begin
        we_q <= we_b_in;
        if (busy > 0 && !susp) busy <= busy - 1;
        if (we_b_in && !we_q && !ce_b_in) begin
            writes <= writes + 1;
            ar <= dq_in == 16'h00aa ? 1 : ar == 1 && dq_in == 16'h0055 ? 2 : 0;
            if (st < 3) sect <= addr_in;
            case (busy > 0 ? 9 : st)
                0, 1, 2: bad = dq_in[7:0] != code[st] ||
                    st < 2 && addr_in[11:0] != (byte_mode_in ? 12'haaa : 12'h555) >> st;
                3: bad = !sect_ok || dq_in > 16'h00ff;
                4: bad = !in_line;
                5: bad = !sect_ok || dq_in[7:0] != 8'h29;
                default: bad = 1'b0;
            endcase
            if (busy > 0) begin
                if (dq_in == 16'h0051 || dq_in == 16'h00b0) susp <= 1'b1;
                if (dq_in == 16'h0050 || dq_in == 16'h0030) susp <= 1'b0;
            end else if (ar == 2 && dq_in == 16'h00f0) begin
                st <= 0;
                resets <= resets + 1;
            end else if (bad || st == 6) begin
                aborted <= aborted | bad;
                st <= 6;
            end else begin
                st <= st == 4 && n < rem ? 4 : st == 5 ? 0 : st + 1;
                n <= st == 4 ? n + 1 : 0;
                nx <= addr_in + 26'h1;
                sum <= st == 4 ? sum ^ dq_in : sum;
                rem <= st == 3 ? int'(dq_in) : rem;
                busy <= st == 5 ? BUSY_CYC : 0;
            end
        end
    end
endmodule : fwb_flash_model
`default_nettype wire

// ===== tb/test_flash_write_buffer_program_suspend.sv
// self-checking bench for the buffer-program host sequencer
`timescale 1ns/10ps
`default_nettype none
module test_flash_write_buffer_program_suspend;
    logic        clk = 1'b0, rst_b = 1'b0, bm = 1'b0, st = 1'b0, sus = 1'b0, res = 1'b0;
    logic        lv = 1'b0, ab = 1'b0, lr, done, susp, refd, we_b, ce_b, rdy, busy, oe_b;
    logic [25:0] a = '0, fa;
    logic [15:0] d = '0, fd, x;
    logic [7:0]  cnt = '0;
    int          fails = 0, samples_checked = 0, nref = 0, seed, w0, k, i;
    fwb_host uut (.ref_clk_in(clk), .rst_b_in(rst_b), .byte_mode_in(bm), .start_in(st),
        .start_addr_in(a), .load_count_minus_one_in(cnt), .suspend_in(sus), .resume_in(res),
        .abort_reset_in(ab), .load_valid_in(lv), .load_ready_out(lr), .busy_out(busy),
        .program_word_value_in(d), .done_out(done), .suspended_out(susp), .refused_out(refd),
        .flash_addr_out(fa), .flash_dq_out(fd), .flash_dq_oe_b_out(oe_b), .flash_we_b_out(we_b),
        .flash_ce_b_out(ce_b), .flash_ready_in(rdy));
    fwb_flash_model m (.ref_clk_in(clk), .byte_mode_in(bm), .addr_in(fa), .dq_in(fd),
        .we_b_in(we_b), .ce_b_in(ce_b), .ready_out(rdy));
    task automatic check(input string n, input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask : check
    task automatic final_report;
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) if (refd === 1'b1) nref <= nref + 1;
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        final_report;
    end
    initial begin
        seed = 32'hffb7d763;
        tick(3);
        rst_b = 1'b1;
        for (k = 0; k < 4; k++) begin
            bm = k[0];
            cnt = k == 0 ? 8'h00 : k == 2 ? 8'hff : 8'($random(seed) & 7);
            // last load lands at offset 0ffh, the final location of the line in word mode
            a = 26'($random(seed)) & 26'h3fffe00 | 26'(8'hff - cnt);
            w0 = m.writes;
            x = m.sum;
            pulse(st);
            check("busy", busy, 1'b1);
            for (i = 0; i <= int'(cnt); i++) begin
                d = 16'($random(seed));
                x ^= d;
                lv = 1'b1;
                while (lr !== 1'b1) tick(1);
                tick(1);
            end
            lv = 1'b0;
            if (k == 3) begin
                while (m.busy == 0) tick(1);
                tick(1);
                pulse(sus);
                while (susp !== 1'b1) tick(1);
                check("held", m.susp, 1'b1);
                pulse(res);
                while (rdy !== 1'b0) tick(1);
                tick(1);
                pulse(sus);
                pulse(res);
            end
            while (done !== 1'b1) tick(1);
            check("idle", busy, 1'b0);
            check("writes", m.writes - w0, 6 + cnt + (k == 3 ? 2 : 0));
            check("aborted", m.aborted, 1'b0);
            check("data", m.sum, x);
        end
        check("refusals", nref, 2);
        pulse(res);
        tick(4);
        check("refusals", nref, 2);
        w0 = m.writes;
        pulse(ab);
        while (done !== 1'b1) tick(1);
        tick(6);
        check("abort writes", m.writes - w0, 3);
        check("abort resets", m.resets, 1);
        check("bus idle", {oe_b, ce_b, we_b}, 3'b111);
        final_report;
    end
endmodule : test_flash_write_buffer_program_suspend
`default_nettype wire
